// >>> gafm_far_model.sv
// Far side model: port devices and hot-plug expander
`timescale 1ns/10ps
`default_nettype none
module gafm_far_model (
    input wire logic [6:0] pad_o, pad_oe, ext_lvl,
    output logic [6:0] pad_i
);
    // Driven pins read back; others follow expander lines
    assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_lvl);
endmodule
`default_nettype wire

// >>> gafm_mux.sv
// Pin mux top for general purpose pins 0 to 6
// Notes on behaviour
// - Names ending _n are asserted when low
// - Pins 0..6 usable as plain bit I/O
// - Pin 0 alternate drives port B reset
// - Pin 1 alternate drives port D reset
// - Pins 2..4 alternate take expander interrupts
// - Each pin direction set independently
// - Alternate enable from software, SMBus, or EEPROM
`timescale 1ns/10ps
`default_nettype none
module gafm_mux
    import gafm_pkg::*;
#(
    parameter int PINS = GAFM_PIN_COUNT
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Software GPIO configuration
    input wire logic [PINS-1:0] gpio_dir,
    input wire logic [PINS-1:0] gpio_out,
    output logic [PINS-1:0] gpio_in,
    // Alternate enable writes from the three configuration sources
    input wire logic alt_sw_wr,
    input wire logic [PINS-1:0] alt_sw_val,
    input wire logic alt_smb_wr,
    input wire logic [PINS-1:0] alt_smb_val,
    input wire logic alt_eeprom_wr,
    input wire logic [PINS-1:0] alt_eeprom_val,
    output logic [PINS-1:0] alt_en,
    output logic [1:0] alt_last_src,
    // Internal alternate function signals
    input wire logic port_b_reset_req,
    input wire logic port_d_reset_req,
    output logic [GAFM_IRQ_COUNT-1:0] expander_irq,
    // Pads
    input wire logic [PINS-1:0] pad_i,
    output logic [PINS-1:0] pad_o,
    output logic [PINS-1:0] pad_oe
);
    logic [PINS-1:0] alt_q, alt_d;
    gafm_src_e src_q, src_d;
    logic [PINS-1:0] alt_drive_n;
    logic [PINS-1:0] alt_sense_n;
    wire downstream_port_b_reset_out = ~port_b_reset_req;
    wire downstream_port_d_reset_out = ~port_d_reset_req;
    wire expander_irq_in_0 = alt_sense_n[GAFM_PIN_IRQ_0];
    wire expander_irq_in_1 = alt_sense_n[GAFM_PIN_IRQ_1];
    wire expander_irq_in_2 = alt_sense_n[GAFM_PIN_IRQ_2];

    // Fixed priority when sources collide: software last word wins
    assign alt_d = alt_sw_wr ? alt_sw_val :
                   alt_smb_wr ? alt_smb_val :
                   alt_eeprom_wr ? alt_eeprom_val : alt_q;
    assign src_d = alt_sw_wr ? GAFM_SRC_SW :
                   alt_smb_wr ? GAFM_SRC_SMB :
                   alt_eeprom_wr ? GAFM_SRC_EEPROM : src_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alt_q <= GAFM_ALT_RESET;
            src_q <= GAFM_SRC_NONE;
        end else begin
            alt_q <= alt_d;
            src_q <= src_d;
        end
    end
    assign alt_en = alt_q & GAFM_ALT_CAPABLE[PINS-1:0];
    assign alt_last_src = src_q;

    always_comb begin
        alt_drive_n = {PINS{GAFM_DEASSERTED_N}};
        alt_drive_n[GAFM_PIN_PORT_B_RST] = downstream_port_b_reset_out;
        alt_drive_n[GAFM_PIN_PORT_D_RST] = downstream_port_d_reset_out;
    end
    // Expander asserts low on input change; hot-plug logic then reads it
    assign expander_irq = ~{expander_irq_in_2, expander_irq_in_1, expander_irq_in_0};

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            gafm_pin_cell #(
                .ALT_CAPABLE(GAFM_ALT_CAPABLE[g]),
                .ALT_OUTPUT(GAFM_ALT_IS_OUTPUT[g])
            ) u_cell (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .gpio_dir(gpio_dir[g]),
                .gpio_out(gpio_out[g]),
                .alt_en(alt_q[g]),
                .alt_drive_n(alt_drive_n[g]),
                .alt_sense_n(alt_sense_n[g]),
                .pin_i(pad_i[g]),
                .pin_o(pad_o[g]),
                .pin_oe(pad_oe[g]),
                .gpio_in(gpio_in[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// >>> gafm_mux_asserts.sv
// Assertion checker for the pin alternate function mux
`timescale 1ns/10ps
`default_nettype none
module gafm_mux_asserts import gafm_pkg::*; #(parameter int PINS = GAFM_PIN_COUNT) (
    input wire logic clk_sys, rst_n, alt_sw_wr, alt_smb_wr, alt_eeprom_wr, port_b_reset_req, port_d_reset_req,
    input wire logic [PINS-1:0] alt_sw_val, alt_smb_val, alt_en, pad_i, pad_o, pad_oe, gpio_dir, gpio_out,
    input wire logic [1:0] alt_last_src,
    input wire logic [GAFM_IRQ_COUNT-1:0] expander_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    alt_mask_a: assert property (alt_en[6:5] == 2'h0) else $error("mask");
    sw_take_a: assert property (alt_sw_wr |=> alt_en == ($past(alt_sw_val) & 7'h1F)) else $error("sw");
    smb_take_a: assert property (!alt_sw_wr && alt_smb_wr |=> alt_en == ($past(alt_smb_val) & 7'h1F)) else $error("smb");
    ee_src_a: assert property (!alt_sw_wr && !alt_smb_wr && alt_eeprom_wr |=> alt_last_src == 2'h3) else $error("ee");
    port_b_rst_a: assert property (alt_en[0] |=> pad_oe[0] && pad_o[0] == !$past(port_b_reset_req)) else $error("b");
    port_d_rst_a: assert property (alt_en[1] |=> pad_oe[1] && pad_o[1] == !$past(port_d_reset_req)) else $error("d");
    irq_in_a: assert property (alt_en[2] |=> !pad_oe[2] && expander_irq[0] == !$past(pad_i[2])) else $error("irq");
    irq_idle_a: assert property (!alt_en[3] |=> !expander_irq[1]) else $error("idle");
    // Software write of pin 0 reaches the pad two edges later
    sequence sw_pin0_s;
        alt_sw_wr && alt_sw_val[0];
    endsequence
    sequence pin0_drive_s;
        ##1 pad_oe[0];
    endsequence
    alt_sw_pad_a: assert property (sw_pin0_s |=> pin0_drive_s) else $error("swpad");
    plain_dir_a: assert property (1'b1 |=> pad_oe[6:5] == $past(gpio_dir[6:5])) else $error("dir");
    plain_out_a: assert property (1'b1 |=> pad_o[6:5] == $past(gpio_out[6:5])) else $error("out");
endmodule
bind gafm_mux gafm_mux_asserts #(.PINS(PINS)) gafm_mux_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .alt_sw_wr(alt_sw_wr), .alt_smb_wr(alt_smb_wr), .alt_eeprom_wr(alt_eeprom_wr),
    .port_b_reset_req(port_b_reset_req), .port_d_reset_req(port_d_reset_req),
    .alt_sw_val(alt_sw_val), .alt_smb_val(alt_smb_val), .alt_en(alt_en),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .gpio_dir(gpio_dir), .gpio_out(gpio_out),
    .alt_last_src(alt_last_src), .expander_irq(expander_irq));
`default_nettype wire

// >>> gafm_pin_cell.sv
// One general purpose pin with optional alternate function
`timescale 1ns/10ps
`default_nettype none
module gafm_pin_cell
    import gafm_pkg::*;
#(
    parameter bit ALT_CAPABLE = 1'b0,
    parameter bit ALT_OUTPUT = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Configuration
    input wire logic gpio_dir,
    input wire logic gpio_out,
    input wire logic alt_en,
    // Alternate function side
    input wire logic alt_drive_n,
    output logic alt_sense_n,
    // Pin side
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic gpio_in
);
    logic o_q, o_d, oe_q, oe_d, in_q, alt_q, alt_d;
    wire use_alt = ALT_CAPABLE && alt_en;
    assign o_d = use_alt ? (ALT_OUTPUT ? alt_drive_n : 1'b0) : gpio_out;
    assign oe_d = use_alt ? ALT_OUTPUT : gpio_dir;
    // Input pins seen by the alternate logic only when selected
    assign alt_d = (use_alt && !ALT_OUTPUT) ? pin_i : GAFM_DEASSERTED_N;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_q <= 1'b0;
            oe_q <= 1'b0;
            in_q <= 1'b0;
            alt_q <= GAFM_DEASSERTED_N;
        end else begin
            o_q <= o_d;
            oe_q <= oe_d;
            in_q <= pin_i;
            alt_q <= alt_d;
        end
    end
    assign pin_o = o_q;
    assign pin_oe = oe_q;
    assign gpio_in = in_q;
    assign alt_sense_n = alt_q;
endmodule
`default_nettype wire

// >>> gafm_pkg.sv
// Constants for the general purpose pin alternate function mux
package gafm_pkg;
    localparam int GAFM_PIN_COUNT = 7;
    localparam int GAFM_PIN_PORT_B_RST = 0;
    localparam int GAFM_PIN_PORT_D_RST = 1;
    localparam int GAFM_PIN_IRQ_0 = 2;
    localparam int GAFM_PIN_IRQ_1 = 3;
    localparam int GAFM_PIN_IRQ_2 = 4;
    localparam int GAFM_IRQ_COUNT = 3;
    // Pins 5 and 6 have no alternate function
    localparam logic [6:0] GAFM_ALT_CAPABLE = 7'h1F;
    localparam logic [6:0] GAFM_ALT_IS_OUTPUT = 7'h03;
    localparam logic [6:0] GAFM_DIR_RESET = 7'h00;
    localparam logic [6:0] GAFM_OUT_RESET = 7'h00;
    localparam logic [6:0] GAFM_ALT_RESET = 7'h00;
    // Active-low level held by an idle expander interrupt and released reset
    localparam logic GAFM_DEASSERTED_N = 1'b1;
    typedef enum logic [1:0] {
        GAFM_SRC_NONE = 2'b00,
        GAFM_SRC_SW = 2'b01,
        GAFM_SRC_SMB = 2'b10,
        GAFM_SRC_EEPROM = 2'b11
    } gafm_src_e;
endpackage

// >>> tb_top.sv
// Self-checking bench for the pin alternate function mux
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("BAD %s %h %h", n, e, g); end end
module tb_top;
    logic clk_sys = 0, rst_n = 0, rb = 0, rd = 0;
    logic [2:0] wr = 0, irq;
    logic [6:0] dir = 0, dout = 0, av = 0, ext = 0, gin, aen, pi, po, poe;
    logic [1:0] src;
    int bad_count = 0, n_tests = 0;
    gafm_mux gafm_mux_i (.clk_sys(clk_sys), .rst_n(rst_n), .gpio_dir(dir), .gpio_out(dout), .gpio_in(gin),
        .alt_sw_wr(wr[0]), .alt_sw_val(av), .alt_smb_wr(wr[1]), .alt_smb_val(av), .alt_eeprom_wr(wr[2]),
        .alt_eeprom_val(~av), .alt_en(aen), .alt_last_src(src), .port_b_reset_req(rb), .port_d_reset_req(rd),
        .expander_irq(irq), .pad_i(pi), .pad_o(po), .pad_oe(poe));
    gafm_far_model gafm_far_model_i (.pad_o(po), .pad_oe(poe), .ext_lvl(ext), .pad_i(pi));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic tick(int n); repeat (n) @(negedge clk_sys); endtask
    // Eeprom mask is the inverse, so priority shows in alt_en
    task automatic wr_alt(logic [2:0] s); av = 7'h7F; wr = s; tick(1); wr = 0; tick(2); endtask
    task automatic t_gpio;
        dir = 7'h55; dout = 7'h3C; ext = 7'h2A; tick(3);
        `CHK("oe", 7'h55, poe)
        `CHK("o", 7'h14, po & 7'h55)
        `CHK("in", 7'h3E, gin)
    endtask
    task automatic t_alt;
        wr_alt(3'h1);
        `CHK("en", 7'h1F, aen)
        `CHK("src", 2'h1, src)
        rb = 1; ext = 7'h08; tick(3);
        `CHK("rst", 2'h2, po[1:0])
        `CHK("oe", 7'h43, poe)
        `CHK("irq", 3'h5, irq)
        rb = 0; rd = 1; tick(2);
        `CHK("rst", 2'h1, po[1:0])
    endtask
    // Mid-run reset: everything idles, then plain GPIO resumes
    task automatic t_reset;
        rst_n = 0;
        tick(2);
        `CHK("rpoe", 7'h00, poe)
        `CHK("rpo", 7'h00, po)
        `CHK("rgin", 7'h00, gin)
        `CHK("raen", 7'h00, aen)
        `CHK("rsrc", 2'h0, src)
        `CHK("rirq", 3'h0, irq)
        rst_n = 1;
        tick(2);
        `CHK("gin", 7'h1C, gin)
    endtask
    task automatic t_prio;
        wr_alt(3'h6);
        `CHK("src", 2'h2, src)
        `CHK("en", 7'h1F, aen)
        wr_alt(3'h4);
        `CHK("src", 2'h3, src)
        `CHK("irq", 3'h0, irq)
        `CHK("oe", 7'h55, poe)
    endtask
    task automatic wrap_up;
        $display("checks %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        tick(16);
        rst_n = 1;
        tick(1);
        t_gpio;
        t_alt;
        t_reset;
        t_prio;
        wrap_up;
    end
    initial begin
        #20000;
        bad_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
